//--- rtl/uab_top.sv
// autobaud measurement, frame format and transmit path of a serial port
// assumes classic wishbone master on clk_i, async rx pin, and a neighbour
// receiver on the same clock supplying received data and a done pulse
//
// What this block does
// - measure only async mode with wake-enable clear
// - autobaud enable clears counter, waits start bit
// - counting starts at first rising rx edge
// - fifth rising edge leaves count, clears enable
// - counter wrap sets software-writable overflow flag
// - overflow keeps measuring, enable stays set
// - count clock Fosc/512, /128 or /32
// - both divisor bytes count as one 16-bit counter
// - receiver held idle while measuring
// - fifth edge sets receive flag, cleared by read
// - with wake enable, measure character after break
// - async NRZ frame: start, 8/9 data, stop
// - lsb first, shared format and rate
// - baud clock x16 or x64 of bit rate
// - no hardware parity, ninth bit from software
// - shifter reloads only after stop bit sent
// - transfer takes one cycle, sets buffer-empty flag
// - buffer-empty clears in second cycle after load
// - read-only shift-empty bit, no interrupt
// - transmit enable sets buffer-empty flag
//
// Our own choices: the Wishbone interface to the registers and the address map.
`include "uab_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module uab_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_i,
  input wire logic [7:0] rcv_data_i,
  input wire logic rcv_done_i,
  output logic tx_o,
  output logic rx_hold_idle_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [8:0] abd_lim(input logic w, input logic h);
    case ({w, h})
      2'b00: abd_lim = `UAB_ABD_DIV_SLOW;
      2'b11: abd_lim = `UAB_ABD_DIV_FAST;
      default: abd_lim = `UAB_ABD_DIV_MID;
    endcase
  endfunction : abd_lim

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic rx_m_r, rx_s_r, rx_d_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic nine_r, transmit_enable_r, sync_r, high_speed_baud_select_r, transmit_ninth_bit_r, serial_port_enable_r;
  logic ovf_r, wide_divisor_select_r, wue_r, autobaud_enable_r, brk_low_r;
  logic [15:0] div_r;
  logic [7:0] txb_r;
  logic buf9_r, buf_full_r, tbe_r, tbe_clr_r;
  logic rflag_r;
  uab_pkg::uab_ab_e ab_r;
  logic [2:0] edges_r;
  logic [8:0] presc_r;
  logic [15:0] bcnt_r;
  logic [5:0] ovs_r;
  logic [9:0] tsr_r;
  logic [3:0] left_r;
  logic busy_r, tx_r, hold_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire rise = rx_s_r & ~rx_d_r;
  wire fall = ~rx_s_r & rx_d_r;
  wire req = cyc_i & stb_i & ~ack_r;
  wire wr = req & we_i & sel_i[0];
  wire rd = req & ~we_i;
  wire wr_txsc = wr & (adr_i == `UAB_IX_TXSC);
  wire wr_rxsc = wr & (adr_i == `UAB_IX_RXSC);
  wire wr_bctl = wr & (adr_i == `UAB_IX_BCTL);
  // buffer writes during autobaud are dropped: no baud clock to send them
  wire wr_txb = wr & (adr_i == `UAB_IX_TXB) & ~autobaud_enable_r;
  wire wr_divh = wr & (adr_i == `UAB_IX_DIVH);
  wire wr_divl = wr & (adr_i == `UAB_IX_DIVL);
  wire rd_rxd = rd & (adr_i == `UAB_IX_RXD);
  wire [7:0] wd = dat_i[7:0];

  wire ab_ok = autobaud_enable_r & ~sync_r & ~wue_r;
  wire abd_set = wr_bctl & wd[`UAB_B_AUTOBAUD_ENABLE] & ~autobaud_enable_r;
  wire meas = (ab_r != uab_pkg::UAB_AB_OFF);
  wire counting = (ab_r == uab_pkg::UAB_AB_COUNT);
  wire [8:0] plim = abd_lim(wide_divisor_select_r, high_speed_baud_select_r);
  wire ptick = counting & (presc_r == plim);
  wire wrap = ptick & (div_r == 16'hFFFF);
  wire ab_done = counting & rise & (edges_r == `UAB_EDGE_LAST);
  wire wake = wue_r & fall;
  wire wake_end = wue_r & brk_low_r & rise;

  wire port_on = serial_port_enable_r & ~sync_r & transmit_enable_r;
  wire [15:0] blim = wide_divisor_select_r ? div_r : {8'h00, div_r[7:0]};
  wire btick = busy_r & ~meas & (bcnt_r == 16'h0000);
  wire [5:0] olim = (wide_divisor_select_r | high_speed_baud_select_r) ? `UAB_OVS_X16 : `UAB_OVS_X64;
  wire bit_tick = btick & (ovs_r == olim);
  wire xfer = buf_full_r & ~busy_r & port_on & ~meas;
  wire transmit_enable_rise = wr_txsc & wd[`UAB_B_TRANSMIT_ENABLE] & ~transmit_enable_r;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] rmux;
  assign rmux =
    (adr_i == `UAB_IX_TXSC) ? {1'b0, nine_r, transmit_enable_r, sync_r, 1'b0,
                               high_speed_baud_select_r, ~busy_r, transmit_ninth_bit_r} :
    (adr_i == `UAB_IX_RXSC) ? {serial_port_enable_r, 7'h00} :
    (adr_i == `UAB_IX_BCTL) ? {ovf_r, 3'h0, wide_divisor_select_r, 1'b0, wue_r,
                               autobaud_enable_r} :
    (adr_i == `UAB_IX_TXB) ? txb_r :
    (adr_i == `UAB_IX_DIVH) ? div_r[15:8] :
    (adr_i == `UAB_IX_DIVL) ? div_r[7:0] :
    (adr_i == `UAB_IX_STAT) ? {5'h00, meas, rflag_r, tbe_r} :
    rcv_data_i;

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  uab_pkg::uab_ab_e ab_nxt;
  always_comb begin
    ab_nxt = ab_r;
    case (ab_r)
      uab_pkg::UAB_AB_OFF: begin
        if (ab_ok) ab_nxt = uab_pkg::UAB_AB_START;
      end
      uab_pkg::UAB_AB_START: begin
        if (!ab_ok) ab_nxt = uab_pkg::UAB_AB_OFF;
        else if (fall) ab_nxt = uab_pkg::UAB_AB_FIRST;
      end
      uab_pkg::UAB_AB_FIRST: begin
        if (!ab_ok) ab_nxt = uab_pkg::UAB_AB_OFF;
        else if (rise) ab_nxt = uab_pkg::UAB_AB_COUNT;
      end
      uab_pkg::UAB_AB_COUNT: begin
        if (!ab_ok || ab_done) ab_nxt = uab_pkg::UAB_AB_OFF;
      end
      default: ab_nxt = uab_pkg::UAB_AB_OFF;
    endcase
  end

  // divisor doubles as the measurement counter
  logic [15:0] div_nxt;
  always_comb begin
    div_nxt = div_r;
    if (wr_divh) div_nxt[15:8] = wd;
    if (wr_divl) div_nxt[7:0] = wd;
    if (abd_set) div_nxt = `UAB_RST_DIV;
    else if (ptick) div_nxt = div_r + 16'h0001;
  end

  // ----------------------------------------
  // pin sync and bus
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    rx_m_r <= rx_i;
    rx_s_r <= rx_m_r;
    rx_d_r <= rx_s_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (rd) dat_r <= {24'h00_0000, rmux};
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {nine_r, transmit_enable_r, sync_r, high_speed_baud_select_r, transmit_ninth_bit_r, serial_port_enable_r} <= 6'h00;
      {wide_divisor_select_r, wue_r, brk_low_r} <= 3'h0;
      txb_r <= `UAB_RST_BYTE;
      div_r <= `UAB_RST_DIV;
    end else begin
      if (wr_txsc) begin
        nine_r <= wd[`UAB_B_NINE];
        transmit_enable_r <= wd[`UAB_B_TRANSMIT_ENABLE];
        sync_r <= wd[`UAB_B_SYNC];
        high_speed_baud_select_r <= wd[`UAB_B_HIGH_SPEED_BAUD_SELECT];
        transmit_ninth_bit_r <= wd[`UAB_B_TRANSMIT_NINTH_BIT];
      end
      if (wr_rxsc) serial_port_enable_r <= wd[`UAB_B_SERIAL_PORT_ENABLE];
      if (wr_bctl) wide_divisor_select_r <= wd[`UAB_B_WIDE_DIVISOR_SELECT];
      // wake enable drops itself when the break ends
      if (wake_end) wue_r <= 1'b0;
      else if (wr_bctl) wue_r <= wd[`UAB_B_WUE];
      if (!wue_r) brk_low_r <= 1'b0;
      else if (wake) brk_low_r <= 1'b1;
      if (wr_txb) txb_r <= wd;
      div_r <= div_nxt;
    end
  end

  // ----------------------------------------
  // autobaud sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ab_r <= uab_pkg::UAB_AB_OFF;
      autobaud_enable_r <= 1'b0;
      ovf_r <= 1'b0;
      edges_r <= 3'h0;
      presc_r <= 9'h000;
      hold_r <= 1'b0;
    end else begin
      ab_r <= ab_nxt;
      hold_r <= (ab_nxt != uab_pkg::UAB_AB_OFF);
      if (ab_done) autobaud_enable_r <= 1'b0;
      else if (wr_bctl) autobaud_enable_r <= wd[`UAB_B_AUTOBAUD_ENABLE];
      // hardware set beats a software clear in the same cycle
      ovf_r <= wrap | (wr_bctl ? wd[`UAB_B_OVF] : ovf_r);
      if (!counting) edges_r <= 3'h0;
      else if (rise) edges_r <= edges_r + 3'h1;
      presc_r <= (!counting || ptick) ? 9'h000 : presc_r + 9'h001;
    end
  end

  // ----------------------------------------
  // receive flag
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) rflag_r <= 1'b0;
    else if (ab_done | wake | rcv_done_i) rflag_r <= 1'b1;
    else if (rd_rxd) rflag_r <= 1'b0;
  end

  // ----------------------------------------
  // transmit buffer and empty flag
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_full_r <= 1'b0;
      buf9_r <= 1'b0;
      tbe_r <= 1'b0;
      tbe_clr_r <= 1'b0;
    end else begin
      // ninth bit is latched with the data, so set it first
      if (wr_txb) buf9_r <= transmit_ninth_bit_r;
      if (wr_txb) buf_full_r <= 1'b1;
      else if (xfer) buf_full_r <= 1'b0;
      // clearing lags the load by one cycle, as seen by software
      tbe_clr_r <= wr_txb;
      if (xfer | transmit_enable_rise) tbe_r <= 1'b1;
      else if (tbe_clr_r) tbe_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // baud generator and shifter
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt_r <= 16'h0000;
      ovs_r <= 6'h00;
      tsr_r <= 10'h3FF;
      left_r <= 4'h0;
      busy_r <= 1'b0;
      tx_r <= 1'b1;
    end else if (!port_on) begin
      busy_r <= 1'b0;
      tx_r <= 1'b1;
      left_r <= 4'h0;
    end else if (xfer) begin
      tsr_r <= {1'b1, nine_r ? buf9_r : 1'b1, txb_r};
      left_r <= nine_r ? `UAB_BITS_9 : `UAB_BITS_8;
      busy_r <= 1'b1;
      tx_r <= 1'b0;
      bcnt_r <= blim;
      ovs_r <= 6'h00;
    end else if (busy_r && !meas) begin
      bcnt_r <= btick ? blim : bcnt_r - 16'h0001;
      if (btick) ovs_r <= (ovs_r == olim) ? 6'h00 : ovs_r + 6'h01;
      if (bit_tick) begin
        if (left_r != 4'h0) begin
          tx_r <= tsr_r[0];
          tsr_r <= {1'b1, tsr_r[9:1]};
          left_r <= left_r - 4'h1;
        end else begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign tx_o = tx_r;
  assign rx_hold_idle_o = hold_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fifth;
    counting && rise && edges_r == `UAB_EDGE_LAST;
  endsequence

  property p_gate;
    $rose(meas) |-> $past(autobaud_enable_r) && !$past(sync_r) && !$past(wue_r);
  endproperty
  a_gate: assert property (p_gate)
    else $error("measurement began outside async or with wake on");

  property p_clear;
    abd_set |=> div_r == 16'h0000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared on autobaud enable");

  property p_first;
    ab_r == uab_pkg::UAB_AB_FIRST |=> $stable(div_r) || $past(wr);
  endproperty
  a_first: assert property (p_first)
    else $error("counter moved before first rising edge");

  property p_done;
    s_fifth |=> !autobaud_enable_r && rflag_r && !meas;
  endproperty
  a_done: assert property (p_done)
    else $error("fifth edge did not end measurement");

  property p_ovf;
    wrap && ab_ok |=> ovf_r && autobaud_enable_r && counting;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("wrap not trapped or measurement stopped");

  property p_presc;
    counting |-> presc_r <= plim;
  endproperty
  a_presc: assert property (p_presc)
    else $error("measurement prescaler out of range");

  property p_hold;
    meas |-> rx_hold_idle_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("receiver not held idle while measuring");

  property p_idle;
    !busy_r |-> tx_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("line low while shifter idle");

  property p_xfer;
    xfer |=> tbe_r && busy_r && !tx_o;
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("buffer transfer did not set empty flag");

  property p_lag;
    wr_txb && tbe_r |=> tbe_r;
  endproperty
  a_lag: assert property (p_lag)
    else $error("empty flag cleared in the load cycle");

endmodule : uab_top

`default_nettype wire

//--- rtl/uab_defs.svh
// constants for the autobaud serial transmitter slice
// assumes a 32-bit classic wishbone bus with word addressing on adr[4:2]
`ifndef UAB_DEFS_SVH
`define UAB_DEFS_SVH

// ----------------------------------------
// register word index
// ----------------------------------------
`define UAB_IX_TXSC 3'h0
`define UAB_IX_RXSC 3'h1
`define UAB_IX_BCTL 3'h2
`define UAB_IX_TXB 3'h3
`define UAB_IX_DIVH 3'h4
`define UAB_IX_DIVL 3'h5
`define UAB_IX_STAT 3'h6
`define UAB_IX_RXD 3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define UAB_B_NINE 6
`define UAB_B_TRANSMIT_ENABLE 5
`define UAB_B_SYNC 4
`define UAB_B_HIGH_SPEED_BAUD_SELECT 2
`define UAB_B_SHIFT_REGISTER_EMPTY 1
`define UAB_B_TRANSMIT_NINTH_BIT 0
`define UAB_B_SERIAL_PORT_ENABLE 7
`define UAB_B_OVF 7
`define UAB_B_WIDE_DIVISOR_SELECT 3
`define UAB_B_WUE 1
`define UAB_B_AUTOBAUD_ENABLE 0

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define UAB_RST_BYTE 8'h00
`define UAB_RST_DIV 16'h0000
`define UAB_ABD_DIV_SLOW 9'h1FF
`define UAB_ABD_DIV_MID 9'h07F
`define UAB_ABD_DIV_FAST 9'h01F
`define UAB_OVS_X16 6'h0F
`define UAB_OVS_X64 6'h3F
`define UAB_BITS_8 4'h9
`define UAB_BITS_9 4'hA
`define UAB_EDGE_LAST 3'h3

`endif

//--- rtl/uab_pkg.sv
// types for the autobaud serial transmitter slice
// state encodings are set here; the other numeric constants are in uab_defs.svh
package uab_pkg;

  // measurement sequencer states
  typedef enum logic [1:0] {
    UAB_AB_OFF = 2'b00,
    UAB_AB_START = 2'b01,
    UAB_AB_FIRST = 2'b10,
    UAB_AB_COUNT = 2'b11
  } uab_ab_e;

endpackage : uab_pkg

//--- testbench/uab_node.sv
// remote serial node on the rx and tx lines of the transmitter slice
// assumes one shared clock; bit lengths are given in clock cycles
`timescale 1ns/1ps
`default_nettype none

module uab_node #(
  parameter int TX_BIT = 32,
  parameter int CAL_BIT = 160
) (
  input wire logic clk_i,
  input wire logic tx_i,
  input wire logic nine_i,
  input wire logic send_i,
  output logic rx_o,
  output logic [8:0] last_o,
  output int count_o,
  output int bad_o
);
  // ----------------------------------------
  // calibration sender
  // ----------------------------------------
  // stop, 55h, start, sent lsb first; line rests at mark level
  localparam logic [9:0] CAL = 10'h2AA;
  logic [8:0] v;

  initial begin
    rx_o = 1'b1;
    last_o = '0;
    count_o = 0;
    bad_o = 0;
  end

  always begin
    @(posedge send_i);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rx_o <= CAL[i];
      repeat (CAL_BIT - 1) @(posedge clk_i);
    end
  end

  // ----------------------------------------
  // frame receiver, samples mid-bit
  // ----------------------------------------
  always begin
    @(negedge tx_i);
    repeat (TX_BIT / 2) @(posedge clk_i);
    if (tx_i !== 1'b0) bad_o++;
    v = '0;
    for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
      repeat (TX_BIT) @(posedge clk_i);
      v[i] = tx_i;
    end
    repeat (TX_BIT) @(posedge clk_i);
    if (tx_i !== 1'b1) bad_o++;
    last_o = v;
    count_o++;
  end
endmodule : uab_node

`default_nettype wire

//--- testbench/uab_top_tb.sv
// self-checking bench for the autobaud serial transmitter slice
// assumes uab_top and uab_node; bit time 32 clocks, calibration 160
`include "uab_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module uab_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, tx, hold, rx;
  logic nine = 1'b0;
  logic send = 1'b0;
  logic [2:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd;
  logic [7:0] q;
  logic [8:0] last;
  int cnt, bad;
  int errors = 0;
  int checks_done = 0;

  always #10 clk_i = ~clk_i;

  uab_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd),
    .ack_o(ack), .rx_i(rx), .rcv_data_i(8'h5A), .rcv_done_i(1'b0),
    .tx_o(tx), .rx_hold_idle_o(hold));

  uab_node #(.TX_BIT(32), .CAL_BIT(160)) u_node (.clk_i(clk_i),
    .tx_i(tx), .nine_i(nine), .send_i(send), .rx_o(rx), .last_o(last),
    .count_o(cnt), .bad_o(bad));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run;
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; the next call leaves an idle cycle first
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(9'h000, 9'h1AC);
    q = rd[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({1'b0, q}, {1'b0, e});
  endtask : rd_chk

  task automatic wait_cnt(input int n);
    for (int i = 0; i < 2000 && cnt < n; i++) @(posedge clk_i);
  endtask : wait_cnt

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; dat = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 1; i < 7; i++) rd_chk(3'(i), 8'h00);
    rd_chk(`UAB_IX_RXD, 8'h5A);
    bus(1'b1, `UAB_IX_DIVL, 8'h01);
    bus(1'b1, `UAB_IX_RXSC, 8'h80);
    bus(1'b1, `UAB_IX_TXSC, 8'h24);
    rd_chk(`UAB_IX_STAT, 8'h01);
    rd_chk(`UAB_IX_TXSC, 8'h26);
    chk({8'h00, tx}, 9'h001);
    bus(1'b1, `UAB_IX_TXB, 8'hA5);
    rd_chk(`UAB_IX_STAT, 8'h01);
    bus(1'b1, `UAB_IX_TXB, 8'h3C);
    rd_chk(`UAB_IX_STAT, 8'h00);
    rd_chk(`UAB_IX_TXSC, 8'h24);
    wait_cnt(1);
    chk(last, 9'h0A5);
    wait_cnt(2);
    chk(last, 9'h03C);
    repeat (40) @(posedge clk_i);
    rd_chk(`UAB_IX_STAT, 8'h01);
    nine <= 1'b1;
    bus(1'b1, `UAB_IX_TXSC, 8'h65);
    bus(1'b1, `UAB_IX_TXB, 8'h0F);
    wait_cnt(3);
    chk(last, 9'h10F);
    chk(9'(bad), 9'h000);
    nine <= 1'b0;
    repeat (40) @(posedge clk_i);
    // transmitter off first: measurement steals its baud clock
    bus(1'b1, `UAB_IX_TXSC, 8'h04);
    bus(1'b1, `UAB_IX_BCTL, 8'h01);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (400) @(posedge clk_i);
    chk({8'h00, hold}, 9'h001);
    repeat (1300) @(posedge clk_i);
    rd_chk(`UAB_IX_BCTL, 8'h00);
    chk({8'h00, hold}, 9'h000);
    rd_chk(`UAB_IX_DIVH, 8'h00);
    // eight bits of 160 clocks at one count per 128 clocks
    bus(1'b0, `UAB_IX_DIVL, 8'h00);
    chk({8'h00, (q >= 8'h09 && q <= 8'h0B)}, 9'h001);
    bus(1'b0, `UAB_IX_STAT, 8'h00);
    chk({8'h00, q[1]}, 9'h001);
    bus(1'b0, `UAB_IX_RXD, 8'h00);
    bus(1'b0, `UAB_IX_STAT, 8'h00);
    chk({8'h00, q[1]}, 9'h000);
    bus(1'b1, `UAB_IX_BCTL, 8'h80);
    rd_chk(`UAB_IX_BCTL, 8'h80);
    bus(1'b1, `UAB_IX_BCTL, 8'h00);
    rd_chk(`UAB_IX_BCTL, 8'h00);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : uab_top_tb

`default_nettype wire
